//--- pkg/dtr_pkg.sv
// Summary of operation
// - Every terminal is routable by configuration except the safety input, whose function is fixed.
// - Terminals read active high after reset, and the polarity select turns all programmable ones active low.
// - The safety input stays active high whatever polarity is selected.
// - A speed-select filter time is configurable, resets to zero ms, and suppresses momentary selections.
// - Each programmable terminal has a routing field, a readable status bit and an invert bit.
// - After reset the speed, door, direction, brake and drive-healthy functions sit on default terminals.
// - In single direction mode an active direction terminal means up and an inactive one means down.
// - In a dual direction mode the two direction terminals are routed automatically and cannot be changed.
// - Direction mode -1, 0, 1, 2 decode to single/priority, single/binary, dual/binary, dual/priority.
// - In single modes primary at 0 demands clockwise and at 1 counter-clockwise rotation.
// - In dual modes primary at 1 demands counter-clockwise, secondary at 1 clockwise, 0 demands nothing.
// - The direction invert flag reverses the demand but not the displayed primary input value.
package dtr_pkg;

	// ***************************************************
	// Sizes and timing
	// ***************************************************
	localparam int DTR_NUM_TERM = 9;
	localparam int DTR_MAX_TERM = 16;
	localparam int DTR_ADDR_W = 8;
	localparam int DTR_CLK_PERIOD_NS = 100;
	localparam int DTR_FILTER_UNIT_NS = 1000000;
	// Least time, so round up to whole cycles
	localparam int DTR_CYC_PER_MS = (DTR_FILTER_UNIT_NS + DTR_CLK_PERIOD_NS - 1) / DTR_CLK_PERIOD_NS;

	// ***************************************************
	// Register offsets and reset values
	// ***************************************************
	localparam logic [7:0] DTR_OFF_CTRL = 8'h00;
	localparam logic [7:0] DTR_OFF_FILTER = 8'h04;
	localparam logic [7:0] DTR_OFF_INVERT = 8'h08;
	localparam logic [7:0] DTR_OFF_STATUS = 8'h0C;
	localparam logic [7:0] DTR_OFF_ROUTE_LO = 8'h10;
	localparam logic [7:0] DTR_OFF_ROUTE_HI = 8'h14;
	localparam logic [7:0] DTR_OFF_DEMAND = 8'h18;
	localparam logic [31:0] DTR_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] DTR_FILTER_RST = 16'h0000;
	localparam logic [15:0] DTR_INVERT_RST = 16'h0000;
	localparam logic [63:0] DTR_ROUTE_RST = 64'h0000_0007_A965_4321;
	localparam int DTR_CTRL_POL = 0;
	localparam int DTR_CTRL_MODE_LSB = 1;
	localparam int DTR_CTRL_INV = 4;
	localparam logic [1:0] DTR_RESP_OKAY = 2'h0;
	localparam logic [1:0] DTR_RESP_SLVERR = 2'h2;

	// ***************************************************
	// Internal functions a terminal can carry
	// ***************************************************
	localparam logic [3:0] DTR_FN_NONE = 4'h0;
	localparam logic [3:0] DTR_FN_SPD0 = 4'h1;
	localparam logic [3:0] DTR_FN_DOOR = 4'h6;
	localparam logic [3:0] DTR_FN_DIR_PRI = 4'h7;
	localparam logic [3:0] DTR_FN_DIR_SEC = 4'h8;
	localparam logic [3:0] DTR_FN_BRAKE = 4'h9;
	localparam logic [3:0] DTR_FN_HEALTHY = 4'hA;
	localparam int DTR_NUM_SPD = 5;

	// Direction terminal positions in dual modes
	localparam int DTR_TI_SEC = 2;
	localparam int DTR_TI_DIR = 8;

	typedef struct packed {
		logic dual;
		logic prio;
		logic ccw;
		logic cw;
		logic door;
		logic [4:0] speed;
	} dtr_demand_t;

endpackage

//--- core/dtr_core.sv
`timescale 1ns/100ps
`default_nettype none
module dtr_core #(
	parameter int NUM_TERM = dtr_pkg::DTR_NUM_TERM,
	parameter int CYC_PER_MS = dtr_pkg::DTR_CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NUM_TERM-1:0] term_in,
	output logic [NUM_TERM-1:0] term_out,
	output logic [NUM_TERM-1:0] term_oe,
	input wire logic safety_disable_terminal,
	output logic torque_enable,
	input wire logic brake_request,
	input wire logic drive_healthy,
	output dtr_pkg::dtr_demand_t demand,
	input wire logic [dtr_pkg::DTR_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [dtr_pkg::DTR_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import dtr_pkg::*;

	// ***************************************************
	// Elaboration checks
	// ***************************************************
	if (NUM_TERM < DTR_NUM_TERM || NUM_TERM > DTR_MAX_TERM) begin : g_bad_term
		$error("NUM_TERM must lie between 9 and 16");
	end
	if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) begin : g_bad_cyc
		$error("CYC_PER_MS must lie between 1 and 65535");
	end

	// ***************************************************
	// Functions
	// ***************************************************
	// Output sources are driven, everything else is sampled
	function automatic logic is_out(input logic [3:0] fn);
		is_out = (fn == DTR_FN_BRAKE) || (fn == DTR_FN_HEALTHY);
	endfunction

	// Register index from word address, 7 when unmapped
	function automatic logic [2:0] reg_sel(input logic [DTR_ADDR_W-1:0] a);
		logic [7:0] w;
		w = {a[7:2], 2'b00};
		case (w)
			DTR_OFF_CTRL: reg_sel = 3'd0;
			DTR_OFF_FILTER: reg_sel = 3'd1;
			DTR_OFF_INVERT: reg_sel = 3'd2;
			DTR_OFF_STATUS: reg_sel = 3'd3;
			DTR_OFF_ROUTE_LO: reg_sel = 3'd4;
			DTR_OFF_ROUTE_HI: reg_sel = 3'd5;
			DTR_OFF_DEMAND: reg_sel = 3'd6;
			default: reg_sel = 3'd7;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		for (int b = 0; b < 4; b++) begin
			old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
		merge = old;
	endfunction

	// ***************************************************
	// State
	// ***************************************************
	logic [NUM_TERM-1:0] term_s1;
	logic [NUM_TERM-1:0] term_s2;
	logic safe_s1;
	logic safe_s2;
	logic [31:0] ctrl;
	logic [15:0] filt_ms;
	logic [15:0] inv_cfg;
	logic [63:0] route_cfg;
	logic [4:0] spd_prev;
	logic [15:0] pre_cnt;
	logic [15:0] ms_cnt;
	logic pri_disp;
	logic [DTR_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// Control fields
	wire logic pol_neg = ctrl[DTR_CTRL_POL];
	wire logic signed [2:0] dir_mode = ctrl[DTR_CTRL_MODE_LSB +: 3];
	wire logic dir_inv = ctrl[DTR_CTRL_INV];
	wire logic dual = (dir_mode > 3'sd0);
	wire logic prio = (dir_mode == -3'sd1) || (dir_mode == 3'sd2);

	// ***************************************************
	// Pin synchronisers
	// ***************************************************
	// Two stages; only the second is read by any logic
	always_ff @(posedge clk) begin
		if (rst) begin
			term_s1 <= '0;
			term_s2 <= '0;
			safe_s1 <= 1'b0;
			safe_s2 <= 1'b0;
		end else begin
			term_s1 <= term_in;
			term_s2 <= term_s1;
			safe_s1 <= safety_disable_terminal;
			safe_s2 <= safe_s1;
		end
	end

	// ***************************************************
	// Routing and polarity per terminal
	// ***************************************************
	logic [3:0] eff_route [DTR_MAX_TERM];
	logic [DTR_MAX_TERM-1:0] term_val;
	logic [DTR_MAX_TERM-1:0] term_stat;
	logic [DTR_MAX_TERM-1:0] fn_hit [16];
	logic [15:0] fn_in;
	logic [NUM_TERM-1:0] next_out;
	logic [NUM_TERM-1:0] next_oe;

	for (genvar i = 0; i < DTR_MAX_TERM; i++) begin : g_term
		if (i < NUM_TERM) begin : g_used
			// Dual modes pin both direction terminals regardless of the routing field
			assign eff_route[i] = (dual && i == DTR_TI_DIR) ? DTR_FN_DIR_PRI :
				(dual && i == DTR_TI_SEC) ? DTR_FN_DIR_SEC : route_cfg[i*4 +: 4];
			assign term_val[i] = term_s2[i] ^ pol_neg ^ inv_cfg[i];
			// Source for driven terminals, polarity and invert applied on the way out
			assign next_out[i] = ((eff_route[i] == DTR_FN_BRAKE) ? brake_request :
				(eff_route[i] == DTR_FN_HEALTHY) ? drive_healthy : 1'b0)
				^ pol_neg ^ inv_cfg[i];
			assign next_oe[i] = is_out(eff_route[i]);
			assign term_stat[i] = term_oe[i] ? (term_out[i] ^ pol_neg ^ inv_cfg[i]) : term_val[i];
		end else begin : g_spare
			assign eff_route[i] = DTR_FN_NONE;
			assign term_val[i] = 1'b0;
			assign term_stat[i] = 1'b0;
		end
	end

	// Gather each internal function from whichever terminals carry it
	for (genvar f = 0; f < 16; f++) begin : g_fn
		for (genvar j = 0; j < DTR_MAX_TERM; j++) begin : g_hit
			assign fn_hit[f][j] = (eff_route[j] == 4'(f)) && !is_out(eff_route[j]) && term_val[j];
		end
		assign fn_in[f] = |fn_hit[f];
	end

	// ***************************************************
	// Speed-select filter
	// ***************************************************
	wire logic [4:0] raw_spd = fn_in[DTR_FN_SPD0 +: DTR_NUM_SPD];
	wire logic spd_moved = (raw_spd != spd_prev);
	wire logic ms_tick = (pre_cnt == 16'(CYC_PER_MS - 1));
	// Zero setting passes at once; otherwise the pattern must hold
	wire logic spd_pass = (filt_ms == 16'h0000)
		|| (!spd_moved && ms_cnt >= filt_ms);

	// Any change restarts the hold time, so with a nonzero setting glitches never reach the demand
	always_ff @(posedge clk) begin
		if (rst) begin
			spd_prev <= '0;
			pre_cnt <= '0;
			ms_cnt <= '0;
		end else if (spd_moved) begin
			spd_prev <= raw_spd;
			pre_cnt <= '0;
			ms_cnt <= '0;
		end else begin
			pre_cnt <= ms_tick ? 16'h0000 : pre_cnt + 16'h0001;
			ms_cnt <= (ms_tick && ms_cnt != 16'hFFFF) ? ms_cnt + 16'h0001 : ms_cnt;
		end
	end

	// ***************************************************
	// Direction decode
	// ***************************************************
	wire logic pri = fn_in[DTR_FN_DIR_PRI];
	wire logic sec = fn_in[DTR_FN_DIR_SEC];
	// Single: active primary means up (ccw), inactive means down (cw)
	wire logic raw_ccw = pri;
	wire logic raw_cw = dual ? sec : !pri;
	wire logic next_ccw = dir_inv ? raw_cw : raw_ccw;
	wire logic next_cw = dir_inv ? raw_ccw : raw_cw;

	// Demand and pins, all registered
	always_ff @(posedge clk) begin
		if (rst) begin
			demand <= '0;
			pri_disp <= 1'b0;
			term_out <= '0;
			term_oe <= '0;
			torque_enable <= 1'b0;
		end else begin
			demand.speed <= spd_pass ? raw_spd : demand.speed;
			demand.door <= fn_in[DTR_FN_DOOR];
			demand.ccw <= next_ccw;
			demand.cw <= next_cw;
			demand.prio <= prio;
			demand.dual <= dual;
			pri_disp <= pri;
			term_out <= next_out;
			term_oe <= next_oe;
			// Fixed function, never inverted by polarity or routing
			torque_enable <= safe_s2;
		end
	end

	// ***************************************************
	// AXI4-Lite slave
	// ***************************************************
	// Address and data are taken in either order; ready low means held
	wire logic wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire logic [2:0] wr_sel = reg_sel(aw_addr);
	wire logic [2:0] rd_sel = reg_sel(s_axi_araddr);
	logic [31:0] rd_mux;
	// Byte-lane merged write words of the 16-bit fields
	wire logic [31:0] filt_wr = merge({16'h0000, filt_ms}, w_data, w_strb);
	wire logic [31:0] inv_wr = merge({16'h0000, inv_cfg}, w_data, w_strb);

	always_comb begin
		case (rd_sel)
			3'd0: rd_mux = {27'h0, dir_inv, dir_mode, pol_neg};
			3'd1: rd_mux = {16'h0, filt_ms};
			3'd2: rd_mux = {16'h0, inv_cfg};
			3'd3: rd_mux = {15'h0, torque_enable, term_stat};
			3'd4: rd_mux = {eff_route[7], eff_route[6], eff_route[5], eff_route[4],
				eff_route[3], eff_route[2], eff_route[1], eff_route[0]};
			3'd5: rd_mux = {eff_route[15], eff_route[14], eff_route[13], eff_route[12],
				eff_route[11], eff_route[10], eff_route[9], eff_route[8]};
			3'd6: rd_mux = {21'h0, pri_disp, demand};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Handshakes on the five channels
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= DTR_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= DTR_RESP_OKAY;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == 3'd7) ? DTR_RESP_SLVERR : DTR_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= (rd_sel == 3'd7) ? DTR_RESP_SLVERR : DTR_RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Configuration registers; status and demand words are read-only
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= DTR_CTRL_RST;
			filt_ms <= DTR_FILTER_RST;
			inv_cfg <= DTR_INVERT_RST;
			route_cfg <= DTR_ROUTE_RST;
		end else if (wr_go) begin
			case (wr_sel)
				3'd0: ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_001F;
				3'd1: filt_ms <= filt_wr[15:0];
				3'd2: inv_cfg <= inv_wr[15:0];
				3'd4: route_cfg[31:0] <= merge(route_cfg[31:0], w_data, w_strb);
				3'd5: route_cfg[63:32] <= merge(route_cfg[63:32], w_data, w_strb);
				default: ctrl <= ctrl;
			endcase
		end
	end

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	reset_defaults_a: assert property (@(posedge clk) disable iff (1'b0)
		rst |=> (!pol_neg && route_cfg == DTR_ROUTE_RST && filt_ms == 16'h0000))
		else $error("defaults not restored after reset");
	safety_polarity_a: assert property (pol_neg |=> torque_enable == $past(safe_s2))
		else $error("safety input followed polarity");
	dir_force_a: assert property (dual |-> (eff_route[DTR_TI_DIR] == DTR_FN_DIR_PRI
		&& eff_route[DTR_TI_SEC] == DTR_FN_DIR_SEC)) else $error("direction terminals not forced");
	dir_single_a: assert property ((!dual && !dir_inv) |=>
		(demand.ccw == $past(pri) && demand.cw == !$past(pri))) else $error("single decode wrong");
	dir_dual_a: assert property ((dual && !dir_inv) |=>
		(demand.ccw == $past(pri) && demand.cw == $past(sec))) else $error("dual decode wrong");
	dir_invert_a: assert property (dir_inv |=>
		(demand.cw == $past(pri) && pri_disp == $past(pri))) else $error("invert handling wrong");
	filter_zero_a: assert property ((filt_ms == 16'h0000) |=>
		demand.speed == $past(raw_spd)) else $error("zero filter did not pass at once");
	filter_hold_a: assert property ((filt_ms != 16'h0000 && spd_moved) |=>
		$stable(demand.speed)) else $error("filter passed a fresh pattern");
	read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read answer late");

endmodule
`default_nettype wire

//--- tb/dtr_lift_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************
// Lift controller model on the terminal side
// ***************************************************
module dtr_lift_ctrl (
	input wire logic neg_logic,
	input wire logic [8:0] level,
	input wire logic safe_en,
	input wire logic [8:0] dev_out,
	input wire logic [8:0] dev_oe,
	output logic [8:0] term_pin,
	output logic safety_pin
);
	// Device-driven terminals win; others carry the wanted level in the chosen logic sense
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			term_pin[i] = dev_oe[i] ? dev_out[i] : (level[i] ^ neg_logic);
		end
	end
	// Separate safe enable, never derived from any other terminal line
	assign safety_pin = safe_en;
	// Mode changes are applied by register writes only; no store or power cycle here
endmodule
`default_nettype wire

//--- tb/tb_drive_terminal_io_routing.sv
`timescale 1ns/100ps
`default_nettype none
module tb_drive_terminal_io_routing;
	import dtr_pkg::*;
	logic clk, rst, neg, safe, brake, healthy;
	logic [8:0] lvl, pin, t_out, t_oe;
	logic safety_pin, torque;
	dtr_demand_t demand;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [3:0] wstrb;
	int fail_count, check_count;
	logic signed [2:0] modes [4] = '{-3'sd1, 3'sd0, 3'sd1, 3'sd2};
	logic [1:0] dp [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
	// ***************************************************
	// Device, partner, clock
	// ***************************************************
	dtr_core #(.NUM_TERM(9), .CYC_PER_MS(4)) i_dut (.clk(clk), .rst(rst), .term_in(pin),
		.term_out(t_out), .term_oe(t_oe), .safety_disable_terminal(safety_pin),
		.torque_enable(torque), .brake_request(brake), .drive_healthy(healthy), .demand(demand),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	dtr_lift_ctrl i_lift (.neg_logic(neg), .level(lvl), .safe_en(safe), .dev_out(t_out),
		.dev_oe(t_oe), .term_pin(pin), .safety_pin(safety_pin));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// ***************************************************
	// Shared tasks
	// ***************************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Master holds each channel until its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 0;
		@(posedge clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
		rready <= 0;
		@(posedge clk);
	endtask
	// Terminal path is three edges; five gives margin
	task automatic settle();
		repeat (5) @(posedge clk);
	endtask
	// ***************************************************
	// Scenarios
	// ***************************************************
	task automatic t_reset_regs();
		rdr(DTR_OFF_CTRL);
		chk("ctrl", rd, DTR_CTRL_RST);
		rdr(DTR_OFF_FILTER);
		chk("filter", rd, 32'h0000_0000);
		rdr(DTR_OFF_INVERT);
		chk("invert", rd, 32'h0000_0000);
		rdr(DTR_OFF_ROUTE_LO);
		chk("route_lo", rd, 32'hA965_4321);
		rdr(DTR_OFF_ROUTE_HI);
		chk("route_hi", rd, 32'h0000_0007);
		rdr(8'h20);
		chk("unmapped", {rsp, rd[29:0]}, {DTR_RESP_SLVERR, 30'h0});
		wr(8'h24, 32'h0000_0001);
		chk("unmapped wr", {30'h0, rsp}, {30'h0, DTR_RESP_SLVERR});
	endtask
	task automatic t_single_dir();
		brake <= 1;
		healthy <= 0;
		lvl <= 9'h11F;
		settle();
		chk("up", {22'h0, demand}, {22'h0, 5'b00100, 5'h1F});
		chk("outs", {t_oe[7:6], t_out[7:6]}, 32'h0000_000D);
		lvl <= 9'h020;
		settle();
		chk("down", {22'h0, demand}, {22'h0, 5'b00011, 5'h00});
		wr(DTR_OFF_CTRL, 32'h0000_0010);
		lvl <= 9'h100;
		settle();
		chk("inv dir", {22'h0, demand}, {22'h0, 5'b00010, 5'h00});
		rdr(DTR_OFF_DEMAND);
		chk("display", {31'h0, rd[10]}, 32'h0000_0001);
		wr(DTR_OFF_CTRL, 32'h0000_0000);
	endtask
	task automatic t_modes();
		for (int k = 0; k < 4; k++) begin
			wr(DTR_OFF_CTRL, {28'h0, modes[k], 1'b0});
			lvl <= 9'h000;
			settle();
			chk("mode", {30'h0, demand.dual, demand.prio}, {30'h0, dp[k]});
		end
		wr(DTR_OFF_CTRL, 32'h0000_0002);
		// Secondary terminal kept on speed bit 2 before leaving dual mode
		wr(DTR_OFF_ROUTE_LO, 32'hA965_4321);
		rdr(DTR_OFF_ROUTE_LO);
		chk("forced", rd, 32'hA965_4821);
		settle();
		chk("none", {30'h0, demand.ccw, demand.cw}, 32'h0);
		lvl <= 9'h100;
		settle();
		chk("ccw", {30'h0, demand.ccw, demand.cw}, 32'h2);
		lvl <= 9'h004;
		settle();
		chk("cw", {30'h0, demand.ccw, demand.cw}, 32'h1);
		chk("sec not spd", {27'h0, demand.speed}, 32'h0);
		wr(DTR_OFF_CTRL, 32'h0000_0000);
		settle();
		chk("sec back to spd", {27'h0, demand.speed}, 32'h04);
	endtask
	task automatic t_polarity();
		wr(DTR_OFF_CTRL, 32'h0000_0001);
		neg <= 1;
		lvl <= 9'h115;
		brake <= 1;
		safe <= 0;
		settle();
		chk("neg spd", {27'h0, demand.speed}, 32'h15);
		chk("neg brake", {31'h0, t_out[6]}, 32'h0);
		chk("safe lo", {31'h0, torque}, 32'h0);
		safe <= 1;
		settle();
		chk("safe hi", {31'h0, torque}, 32'h1);
		wr(DTR_OFF_CTRL, 32'h0000_0000);
		neg <= 0;
	endtask
	task automatic t_route_inv();
		lvl <= 9'h000;
		// Only the low byte lane is written; upper lanes must stay clear
		wr(DTR_OFF_INVERT, 32'hFFFF_FF01, 4'h1);
		settle();
		chk("inv spd", {27'h0, demand.speed}, 32'h01);
		rdr(DTR_OFF_INVERT);
		chk("inv lanes", rd, 32'h0000_0001);
		rdr(DTR_OFF_STATUS);
		chk("status", {31'h0, rd[0]}, 32'h1);
		wr(DTR_OFF_INVERT, 32'h0000_0000);
		wr(DTR_OFF_ROUTE_LO, 32'hA965_4320);
		lvl <= 9'h001;
		settle();
		chk("rerouted", {27'h0, demand.speed}, 32'h00);
		wr(DTR_OFF_ROUTE_LO, 32'hA965_4321);
	endtask
	// Two ms at four cycles per ms: eight quiet cycles before a pattern passes
	task automatic t_filter();
		lvl <= 9'h000;
		wr(DTR_OFF_FILTER, 32'h0000_0002);
		repeat (20) @(posedge clk);
		lvl <= 9'h003;
		repeat (6) @(posedge clk);
		chk("held", {27'h0, demand.speed}, 32'h00);
		repeat (10) @(posedge clk);
		chk("passed", {27'h0, demand.speed}, 32'h03);
		lvl <= 9'h010;
		repeat (3) @(posedge clk);
		lvl <= 9'h003;
		// Mid-glitch look, off the edge: an unfiltered path would show 10 here
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("glitch mid", {27'h0, demand.speed}, 32'h03);
		repeat (20) @(posedge clk);
		chk("glitch", {27'h0, demand.speed}, 32'h03);
		wr(DTR_OFF_FILTER, 32'h0000_0000);
	endtask
	// ***************************************************
	// Main sequence and watchdog
	// ***************************************************
	initial begin
		rst = 1;
		{neg, brake, healthy, awvalid, wvalid, bready, arvalid, rready} = '0;
		safe = 1;
		lvl = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		fail_count = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_reset_regs();
		t_single_dir();
		t_modes();
		t_polarity();
		t_route_inv();
		t_filter();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
